// file: rtl/cfts_pkg.sv
// Package of constants and types for the CCD frame timing sequencer
package cfts_pkg;
  // ******************************
  // Pixel and frame geometry
  // ******************************
  localparam int CLK_PER_PIX = 16;  // System clocks per pixel period
  localparam int VX_DLY      = 1;   // Pixels from H stop to first V pulse
  localparam int VX_PW       = 90;  // Vertical pulse width, pixels
  localparam int VX_HS       = 30;  // Horizontal setup, pixels
  localparam int VX_TOTAL    = 301; // Vertical transfer period, pixels
  localparam int FL_PER      = 180; // Pixels per flushed line
  localparam int FL_LINES    = 2084;
  localparam int PIX_LINE    = 1050;
  localparam int LINES       = 1046;
  localparam int BIN_LINES   = 522;
  // ******************************
  // Pixel phase windows (start inclusive, stop exclusive)
  // ******************************
  localparam logic [3:0] PH_H2_ON  = 4'h8;
  localparam logic [3:0] PH_RST_ON = 4'h1;
  localparam logic [3:0] PH_RST_OF = 4'h3;
  localparam logic [3:0] PH_CLP_ON = 4'h4;
  localparam logic [3:0] PH_CLP_OF = 4'h7;
  localparam logic [3:0] PH_SMP_ON = 4'ha;
  localparam logic [3:0] PH_SMP_OF = 4'hd;
  localparam logic [3:0] PH_LAST   = 4'hf;
  // ******************************
  // Register map (word index) and reset values
  // ******************************
  localparam logic [1:0]  REG_CTRL   = 2'h0;
  localparam logic [1:0]  REG_STATUS = 2'h1;
  localparam logic [4:0]  CODE_RST   = 5'h00;
  localparam logic [12:0] TICKS_29   = 13'h0dac;
  localparam logic [12:0] TICKS_30   = 13'h1388;
  localparam logic [12:0] TICKS_31   = 13'h1964;
  // Jumper bit positions in the sampled mode word
  localparam int M_CAP = 0;
  localparam int M_BIN = 1;
  localparam int M_SRC = 2;
  localparam int M_AMP = 3;
  typedef enum logic [6:0] {
    S_CLR   = 7'h01,
    S_INIT  = 7'h02,
    S_FLUSH = 7'h04,
    S_INTEG = 7'h08,
    S_VXF   = 7'h10,
    S_LXF   = 7'h20,
    S_LCHK  = 7'h40
  } cfts_state_t;
endpackage

// file: rtl/cfts_sequencer.sv
// Frame timing sequencer: state machine, sensor clocks, sync and bus slave
//
// Summary of operation
// R1 - Jumper low: integrate and read out forever
// R2 - Jumper high: trigger, flush, integrate, read once
// R3 - No binning: diffusion reset after every pixel
// R4 - Binning: accumulate 2x2 charge before sampling
// R5 - Internal source: duration from code register
// R6 - Code maps to multiples of 10 ms tick
// R7 - External source: end on integration-end rise
// R8 - Amp jumper low: normal supply always
// R9 - Amp jumper high: reduced supply while integrating
// R10 - Reset clears counters, state and registers
// R11 - Free running, clear state resets counters
// R12 - Initialize samples jumpers, waits tick edge
// R13 - Flush only triggered: lines, then tick
// R14 - Integration output high throughout integrate
// R15 - Fixed counter timing of vertical transfer
// R16 - Binning: two vertical shifts per readout
// R17 - Pixel counter generates grabber sync signals
// R18 - Binning: gate reset, clamp, sample, sync
// R19 - Line check counts, ends frame or repeats
// R20 - Vertical: 1 delay, 90 pulses, 30 setup
// R21 - 1050 pixels, 1046 lines; binned 525, 522
// R22 - Flush 2084 lines of 180 pixels
// R23 - Pixel is 16 clocks, tick 10 ms
// R24 - Synchronise trigger and integration-end inputs
// R25 - Code zero leaves integrate at once
`timescale 1ns/10ps
`default_nettype none
module cfts_sequencer
  import cfts_pkg::*;
#(
  parameter int PIXELS  = PIX_LINE,
  parameter int NLINES  = LINES,
  parameter int NBLINES = BIN_LINES,
  parameter int NFLUSH  = FL_LINES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Mode jumpers
  input  wire logic        CAPTURE_MODE_SELECT,
  input  wire logic        BIN_SELECT,
  input  wire logic        INTEGRATION_SOURCE_SELECT,
  input  wire logic        AMP_POWERDOWN_SELECT,
  // External timing inputs
  input  wire logic        INTEGRATE_TICK,
  input  wire logic        EXT_TRIGGER,
  input  wire logic        EXT_INTEGRATION_END,
  // Avalon-MM slave
  input  wire logic [1:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Sensor clocks
  output logic             V1,
  output logic             V2,
  output logic             H1,
  output logic             H2,
  output logic             DIFFUSION_RESET_CLOCK,
  output logic             CLAMP,
  output logic             SAMPLE,
  // Frame grabber and supply
  output logic             PIXEL_SYNC,
  output logic             LINE_SYNC,
  output logic             INTEGRATE,
  output logic             REDUCED_AMP_SUPPLY
);
  // ******************************
  // Elaboration checks
  // ******************************
  if (PIXELS < 2 || PIXELS > 2047 || PIXELS % 2 != 0 || NLINES < 1 || NLINES > 4095 ||
      NBLINES < 1 || NBLINES > 4095 || NFLUSH < 1 || NFLUSH > 4095 ||
      VX_DLY + 3 * VX_PW + VX_HS != VX_TOTAL || CLK_PER_PIX != 16) begin : g_chk
    $error("cfts_sequencer: unsupported geometry");
  end

  localparam logic [10:0] PIX_LAST = 11'(PIXELS - 1);
  localparam logic [10:0] VX_LAST  = 11'(VX_TOTAL - 1);
  localparam logic [10:0] FL_LAST  = 11'(FL_PER - 1);
  localparam logic [10:0] V1A_ON   = 11'(VX_DLY);
  localparam logic [10:0] V2_ON    = 11'(VX_DLY + VX_PW);
  localparam logic [10:0] V1B_ON   = 11'(VX_DLY + 2 * VX_PW);
  localparam logic [10:0] V1B_OF   = 11'(VX_DLY + 3 * VX_PW);
  localparam logic [10:0] FL_HALF  = 11'(FL_PER / 2);
  localparam logic [11:0] FL_END   = 12'(NFLUSH);

  // Integration length in 10 ms ticks for each code
  function automatic logic [12:0] code_ticks(input logic [4:0] c);
    logic [12:0] w;
    w = {8'h00, c};
    if (c <= 5'h0a)
      code_ticks = w;
    else if (c <= 5'h13)
      code_ticks = 13'((w - 13'h0009) * 13'h000a);
    else if (c <= 5'h1c)
      code_ticks = 13'((w - 13'h0012) * 13'h0064);
    else if (c == 5'h1d)
      code_ticks = TICKS_29;
    else if (c == 5'h1e)
      code_ticks = TICKS_30;
    else
      code_ticks = TICKS_31;
  endfunction

  function automatic logic in_win(input logic [3:0] p, input logic [3:0] a, input logic [3:0] b);
    in_win = (p >= a) && (p < b);
  endfunction

  // ******************************
  // State record
  // ******************************
  typedef struct packed {
    cfts_state_t st;
    logic [3:0]  ph;
    logic [10:0] pcnt;
    logic [11:0] lcnt;
    logic        vsub;
    logic [12:0] tcnt;
    logic [4:0]  code;
    logic [3:0]  mode;
    logic [2:0]  trg_s;
    logic [2:0]  end_s;
    logic        tick_d;
    logic [10:0] outs;
    logic        wait_r;
    logic [31:0] rdata;
  } cfts_reg_t;

  cfts_reg_t s;
  cfts_reg_t n;
  logic      pix_en;
  logic      tick_rise;
  logic      trg_rise;
  logic      end_rise;
  logic      req;
  logic      bus_done;
  logic [11:0] lim;
  logic      v1_n;
  logic      v2_n;
  logic      hrun;
  logic      gate;
  logic      gate_rc;
  logic [3:0] mode_in;

  assign pix_en    = (s.ph == PH_LAST);
  assign tick_rise = INTEGRATE_TICK & ~s.tick_d;
  // R24 edges from the second and third stages
  assign trg_rise  = s.trg_s[1] & ~s.trg_s[2];
  assign end_rise  = s.end_s[1] & ~s.end_s[2];
  assign req       = AVS_READ | AVS_WRITE;
  assign bus_done  = req & ~s.wait_r;
  // R21 binned frames read fewer line pairs
  assign lim       = s.mode[M_BIN] ? 12'(NBLINES) : 12'(NLINES);
  // Live jumper word, in the bit order of the mode field
  assign mode_in   = {AMP_POWERDOWN_SELECT, INTEGRATION_SOURCE_SELECT, BIN_SELECT, CAPTURE_MODE_SELECT};

  // ******************************
  // Next-state logic
  // ******************************
  always_comb begin
    n = s;
    v1_n = 1'b0;
    v2_n = 1'b0;
    hrun = 1'b0;
    gate = 1'b0;
    gate_rc = 1'b0;
    // R23 pixel divider, sixteen phases
    n.ph = s.ph + 4'h1;
    n.tick_d = INTEGRATE_TICK;
    // R24 three-stage synchronisers
    n.trg_s = {s.trg_s[1:0], EXT_TRIGGER};
    n.end_s = {s.end_s[1:0], EXT_INTEGRATION_END};
    case (s.st)
      // R11 per-frame counters cleared
      S_CLR: begin
        n.pcnt = 11'h000;
        n.lcnt = 12'h000;
        n.tcnt = 13'h0000;
        n.vsub = 1'b0;
        // Fresh jumper sample so the first initialize cycle is not stale
        n.mode = mode_in;
        n.st = S_INIT;
      end
      // R12 sample jumpers, wait for start event
      S_INIT: begin
        // R1 continuous start on tick edge
        if (!s.mode[M_CAP] && tick_rise)
          n.st = S_INTEG;
        // R2 triggered start goes to flush
        if (s.mode[M_CAP] && trg_rise)
          n.st = S_FLUSH;
        // Freeze the word that chose the exit; later states must agree with it
        if (n.st == S_INIT)
          n.mode = mode_in;
      end
      // R13 flush lines, then wait tick edge
      S_FLUSH: begin
        if (s.lcnt == FL_END) begin
          if (tick_rise)
            n.st = S_INTEG;
        end else begin
          // R22 180 pixels per flushed line
          v1_n = (s.pcnt < FL_HALF);
          v2_n = ~v1_n;
          if (pix_en) begin
            n.pcnt = s.pcnt + 11'h001;
            if (s.pcnt == FL_LAST) begin
              n.pcnt = 11'h000;
              n.lcnt = s.lcnt + 12'h001;
            end
          end
        end
      end
      S_INTEG: begin
        if (s.mode[M_SRC]) begin
          // R7 external end on rising edge
          if (end_rise)
            n.st = S_VXF;
        end else begin
          // R5 R6 count ticks against coded length
          if (tick_rise)
            n.tcnt = s.tcnt + 13'h0001;
          // R25 code zero leaves at once
          if (n.tcnt >= code_ticks(s.code))
            n.st = S_VXF;
        end
        if (n.st == S_VXF) begin
          n.pcnt = 11'h000;
          n.lcnt = 12'h000;
          n.vsub = 1'b0;
          n.ph = 4'h0;
        end
      end
      // R15 R20 fixed vertical transfer timing
      S_VXF: begin
        v1_n = (s.pcnt >= V1A_ON && s.pcnt < V2_ON) || (s.pcnt >= V1B_ON && s.pcnt < V1B_OF);
        v2_n = (s.pcnt >= V2_ON && s.pcnt < V1B_ON);
        if (pix_en) begin
          n.pcnt = s.pcnt + 11'h001;
          if (s.pcnt == VX_LAST) begin
            n.pcnt = 11'h000;
            // R16 second shift in binning mode
            if (s.mode[M_BIN] && !s.vsub)
              n.vsub = 1'b1;
            else begin
              n.vsub = 1'b0;
              n.st = S_LXF;
            end
          end
        end
      end
      // R17 pixel counter drives line readout
      S_LXF: begin
        hrun = 1'b1;
        // R18 R4 binning: reset and clamp open each pair, sample and sync close it,
        // so both pixels of a pair pile up on the diffusion before one sample
        gate = s.mode[M_BIN] & ~s.pcnt[0];
        gate_rc = s.mode[M_BIN] & s.pcnt[0];
        if (pix_en) begin
          n.pcnt = s.pcnt + 11'h001;
          if (s.pcnt == PIX_LAST) begin
            n.pcnt = 11'h000;
            n.st = S_LCHK;
          end
        end
      end
      // R19 count line, finish or repeat
      S_LCHK: begin
        n.lcnt = s.lcnt + 12'h001;
        n.st = (n.lcnt == lim) ? S_CLR : S_VXF;
        n.ph = 4'h0;
      end
      default: n.st = S_CLR;
    endcase
    // Registered outputs; R3 reset every pixel unless gated
    n.outs[0] = v1_n;
    n.outs[1] = v2_n;
    n.outs[2] = hrun & (s.ph < PH_H2_ON);
    n.outs[3] = hrun & (s.ph >= PH_H2_ON);
    n.outs[4] = hrun & ~gate_rc & in_win(s.ph, PH_RST_ON, PH_RST_OF);
    n.outs[5] = hrun & ~gate_rc & in_win(s.ph, PH_CLP_ON, PH_CLP_OF);
    n.outs[6] = hrun & ~gate & in_win(s.ph, PH_SMP_ON, PH_SMP_OF);
    n.outs[7] = hrun & ~gate & in_win(s.ph, PH_SMP_ON, PH_SMP_OF);
    n.outs[8] = hrun;
    // R14 integration output follows the state
    n.outs[9] = (n.st == S_INTEG);
    // R8 R9 reduced supply only while integrating
    n.outs[10] = (n.st == S_INTEG) & n.mode[M_AMP];
    // One wait state on every access
    n.wait_r = ~(req & s.wait_r);
    if (req && s.wait_r) begin
      case (AVS_ADDRESS)
        REG_CTRL:   n.rdata = {27'h0000000, s.code};
        REG_STATUS: n.rdata = {4'h0, s.lcnt, 4'h0, s.mode, 1'b0, s.st};
        default:    n.rdata = 32'h00000000;
      endcase
    end
    if (bus_done && AVS_WRITE && AVS_ADDRESS == REG_CTRL)
      n.code = AVS_WRITEDATA[4:0];
  end

  // ******************************
  // State register
  // ******************************
  // R10 everything returns to defaults on reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s <= '0;
      s.st <= S_CLR;
      s.code <= CODE_RST;
      s.wait_r <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign V1                    = s.outs[0];
  assign V2                    = s.outs[1];
  assign H1                    = s.outs[2];
  assign H2                    = s.outs[3];
  assign DIFFUSION_RESET_CLOCK = s.outs[4];
  assign CLAMP                 = s.outs[5];
  assign SAMPLE                = s.outs[6];
  assign PIXEL_SYNC            = s.outs[7];
  assign LINE_SYNC             = s.outs[8];
  assign INTEGRATE             = s.outs[9];
  assign REDUCED_AMP_SUPPLY    = s.outs[10];
  assign AVS_READDATA          = s.rdata;
  assign AVS_WAITREQUEST       = s.wait_r;

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  cont_start_a: assert property (s.st == S_INIT && !s.mode[M_CAP] && tick_rise |=> s.st == S_INTEG) // R12
    else $error("continuous start missed tick edge");
  trig_flush_a: assert property (s.st == S_INIT && s.mode[M_CAP] && trg_rise |=> s.st == S_FLUSH) // R2
    else $error("trigger did not start flush");
  flush_mode_a: assert property (s.st == S_FLUSH |-> s.mode[M_CAP]) // R13
    else $error("flush outside triggered capture");
  integ_out_a: assert property (INTEGRATE == (s.st == S_INTEG)) // R14
    else $error("integration output wrong");
  amp_sel_a: assert property (REDUCED_AMP_SUPPLY |-> INTEGRATE && s.mode[M_AMP]) // R9
    else $error("reduced supply outside integration");
  amp_on_a: assert property (INTEGRATE && s.mode[M_AMP] |-> REDUCED_AMP_SUPPLY) // R9
    else $error("reduced supply missing in integration");
  clr_cnt_a: assert property (s.st == S_CLR |=> s.pcnt == 11'h000 && s.lcnt == 12'h000 && s.tcnt == 13'h0000) // R11
    else $error("frame counters not cleared");
  ext_end_a: assert property (s.st == S_INTEG && s.mode[M_SRC] && end_rise |=> s.st == S_VXF) // R7
    else $error("external end ignored");
  code_zero_a: assert property (s.st == S_INTEG && !s.mode[M_SRC] && s.code == 5'h00 |=> s.st == S_VXF) // R25
    else $error("code zero did not end integration");
  vclk_excl_a: assert property (!(V1 && V2)) // R15
    else $error("vertical clocks overlap");
  bin_gate_a: assert property (s.st == S_LXF && s.mode[M_BIN] && !s.pcnt[0] |=> !PIXEL_SYNC && !SAMPLE) // R18
    else $error("binned pixel not gated");
  bin_hold_a: assert property (s.st == S_LXF && s.mode[M_BIN] && s.pcnt[0] |=> !DIFFUSION_RESET_CLOCK && !CLAMP) // R4
    else $error("binned pair reset before sample");
  frame_end_a: assert property (s.st == S_LCHK && s.lcnt + 12'h001 == lim |=> s.st == S_CLR ##1 s.lcnt == 12'h000) // R19
    else $error("frame did not end at line limit");
  bus_wait_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus wait state wrong");

  trig_frame_c: cover property (s.st == S_FLUSH ##1 s.st == S_INTEG);
  zero_code_c:  cover property (s.st == S_INTEG && !s.mode[M_SRC] && s.code == 5'h00);
  bin_line_c:   cover property (s.st == S_LXF && s.mode[M_BIN]);
  ext_end_c:    cover property (s.st == S_INTEG && s.mode[M_SRC] && end_rise);
  wr_code_c:    cover property (bus_done && AVS_WRITE && AVS_ADDRESS == REG_CTRL);
endmodule
`default_nettype wire

// file: verification/cfts_grabber_model.sv
// Far-side model: frame grabber edge counters and external exposure timer
`timescale 1ns/10ps
`default_nettype none
module cfts_grabber_model #(
  parameter int END_DLY = 100
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Watched lines {integ, supply, diff reset, pixel sync, line sync, v1}
  input  wire logic [5:0]       sig,
  // Exposure timer
  input  wire logic             ext_en,
  output logic      [5:0][15:0] cnt,
  output logic                  ext_end
);
  logic [5:0] prev_r;
  int         dly_r;
  // Count rising edges; the timer ends an exposure a fixed time after it starts
  // timer raises end input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r  <= '0;
      cnt     <= '0;
      dly_r   <= 0;
      ext_end <= 1'b0;
    end else begin
      prev_r <= sig;
      for (int i = 0; i < 6; i++) begin
        if (sig[i] && !prev_r[i]) begin
          cnt[i] <= cnt[i] + 16'h1;
        end
      end
      // Released between exposures so a stale high never ends the next one
      if (ext_en && sig[5]) begin
        dly_r   <= dly_r + 1;
        ext_end <= (dly_r >= END_DLY);
      end else begin
        dly_r   <= 0;
        ext_end <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/cfts_sequencer_bench.sv
// Self-checking bench for the frame timing sequencer
`timescale 1ns/10ps
`default_nettype none
module cfts_sequencer_bench;
  // ******************************
  // Shortened geometry and timing
  // ******************************
  localparam int PX = 8;
  localparam int NL = 3;
  localparam int NB = 2;
  localparam int NF = 4;
  localparam int TP = 400; // Tick period in clocks, stands in for 10 ms
  localparam int ED = 100;
  logic             clk, rstn, cap, bin, src, amp, tick, trig, rd, wr, ext_en, ext_end;
  logic [1:0]       adr;
  logic [31:0]      wdat, rdat;
  logic             wreq, v1, v2, h1, h2, drc, clamp, smp, psync, lsync, integ, rsup;
  logic [5:0][15:0] cnt;
  int               failures, n_tests;
  cfts_sequencer #(.PIXELS(PX), .NLINES(NL), .NBLINES(NB), .NFLUSH(NF)) cfts_sequencer_i (
    .CLK(clk), .RSTN(rstn), .CAPTURE_MODE_SELECT(cap), .BIN_SELECT(bin),
    .INTEGRATION_SOURCE_SELECT(src), .AMP_POWERDOWN_SELECT(amp), .INTEGRATE_TICK(tick),
    .EXT_TRIGGER(trig), .EXT_INTEGRATION_END(ext_end), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .V1(v1), .V2(v2), .H1(h1), .H2(h2), .DIFFUSION_RESET_CLOCK(drc), .CLAMP(clamp),
    .SAMPLE(smp), .PIXEL_SYNC(psync), .LINE_SYNC(lsync), .INTEGRATE(integ),
    .REDUCED_AMP_SUPPLY(rsup));
  cfts_grabber_model #(.END_DLY(ED)) cfts_grabber_model_i (
    .clk(clk), .rstn(rstn), .sig({integ, rsup, drc, psync, lsync, v1}),
    .ext_en(ext_en), .cnt(cnt), .ext_end(ext_end));
  // ******************************
  // Clock, tick and watchdog
  // ******************************
  // Free-running clock
  always #20 clk = ~clk;
  // Unit tick, toggled on rising edges
  always begin
    repeat (TP / 2) @(posedge clk);
    tick <= ~tick;
  end
  // Cut a hang short; the whole run needs about 65k clocks
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    summarize;
  end
  // ******************************
  // Shared tasks
  // ******************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    // Only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wait_cnt(input int i, input int t);
    while (cnt[i] < t) begin
      @(posedge clk);
    end
  endtask
  task wait_integ(input logic lvl);
    while (integ !== lvl) begin
      @(posedge clk);
    end
  endtask
  // Length of the next integration, in clocks
  task integ_len(output int n);
    wait_integ(1'b1);
    n = 0;
    while (integ === 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask
  task summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ******************************
  // Scenarios
  // ******************************
  // Code register reset, masking and unmapped place
  task s_regs;
    logic [31:0] q;
    bus(1'b0, 2'h0, 32'h0, q);
    chk("code reset", 32'h0, q);
    bus(1'b1, 2'h0, 32'hffffffe2, q);
    bus(1'b0, 2'h0, 32'h0, q);
    chk("code", 32'h2, q);
    bus(1'b1, 2'h3, 32'h5, q);
    bus(1'b0, 2'h3, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  // Continuous capture, two-tick exposure with reduced supply
  task s_cont;
    int               n;
    logic [5:0][15:0] c0;
    wait_integ(1'b0);
    integ_len(n);
    chk("integ time", 32'h1, 32'(n >= 2 * TP - 4 && n <= 2 * TP + 4));
    chk("supply off", 32'h0, {31'h0, rsup});
    c0 = cnt;
    wait_integ(1'b1);
    chk("lines", NL, cnt[1] - c0[1]);
    chk("pixels", PX * NL, cnt[2] - c0[2]);
    chk("resets", PX * NL, cnt[3] - c0[3]);
    chk("v1 pulses", 2 * NL, cnt[0] - c0[0]);
    chk("supply", {16'h0, cnt[5]}, {16'h0, cnt[4]});
  endtask
  // Triggered, binned, externally ended capture with amplifier kept on
  task s_trig;
    int               n;
    logic [31:0]      q;
    logic [5:0][15:0] c0, c1;
    cap    <= 1'b1;
    bin    <= 1'b1;
    src    <= 1'b1;
    amp    <= 1'b0;
    ext_en <= 1'b1;
    c0 = cnt;
    wait_cnt(1, c0[1] + NL);
    // Snapshot after the running frame, so its own exposure is not counted as idle
    c1 = cnt;
    repeat (3 * TP) @(posedge clk);
    bus(1'b0, 2'h1, 32'h0, q);
    chk("idle status", 32'h702, q & 32'hf7f);
    chk("idle integ", c1[5], cnt[5]);
    trig <= 1'b1;
    integ_len(n);
    trig <= 1'b0;
    chk("flush lines", NF, cnt[0] - c1[0]);
    chk("ext end", 32'h1, 32'(n >= ED + 2 && n <= ED + 8));
    c0 = cnt;
    wait_cnt(1, c0[1] + NB);
    repeat (2 * TP) @(posedge clk);
    chk("bin lines", NB, cnt[1] - c0[1]);
    chk("bin pixels", PX / 2 * NB, cnt[2] - c0[2]);
    chk("bin resets", PX / 2 * NB, cnt[3] - c0[3]);
    chk("bin v1", 4 * NB, cnt[0] - c0[0]);
    chk("supply kept", 32'h0, cnt[4] - c1[4]);
    chk("one frame", c1[5] + 1, cnt[5]);
  endtask
  // Code zero in continuous capture: integrate holds for one clock only
  task s_zero;
    int          n;
    logic [31:0] q;
    bus(1'b1, 2'h0, 32'h0, q);
    cap <= 1'b0;
    bin <= 1'b0;
    src <= 1'b0;
    integ_len(n);
    chk("zero integ", 32'h1, n);
  endtask
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    clk      = 1'b0;
    rstn     = 1'b0;
    {cap, bin, src, trig, tick, rd, wr} = '0;
    amp      = 1'b1;
    ext_en   = 1'b0;
    adr      = 2'h0;
    wdat     = 32'h0;
    failures = 0;
    n_tests  = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    s_regs;
    s_cont;
    s_trig;
    s_zero;
    summarize;
  end
endmodule
`default_nettype wire
